// ---- core/scg_port_drive.sv ----
// One serial port's transmit direction and output gating.
// Assumes the port core reports pending bytes and its request-to-send bit.
`timescale 1ns/1ps
module scg_port_drive
  import scg_pkg::*;
(
  input wire logic i_line_standard,
  input wire logic i_auto_direction,
  input wire logic i_output_enable,
  input wire logic i_tx_pending,
  input wire logic i_rts,
  input wire logic i_txd,
  output logic o_txd,
  output logic o_rts,
  output logic o_driver_enable
);
  logic dir_enable;

  // Direction control of the transceiver driver
  always_comb begin
    if (!i_line_standard) begin
      dir_enable = 1'b1;
    end else if (i_auto_direction) begin
      dir_enable = i_tx_pending;
    end else begin
      dir_enable = ~i_rts;
    end
  end

  // Output gating by the port output enable
  assign o_driver_enable = dir_enable & i_output_enable;
  assign o_txd = i_output_enable ? i_txd : 1'b1;
  assign o_rts = i_output_enable ? i_rts : 1'b1;
endmodule

// ---- core/scg_top.sv ----
// Serial port configuration glue: registers, decode and direction control.
// Assumes host register access arrives as one-cycle byte strobes on I_REF_CLK.
// Function
// - Bit 7 of second port control enables interrupt forwarding, reset 0.
// - Bits 6-4 select the serial IRQ slot, reset 000.
// - Bits 3-0 select the second port base address, reset 0001.
// - Auto direction in RS-422/485 drives while bytes remain.
// - Manual direction: request-to-send 0 enables, 1 tri-states.
// - Mode one bit 5 is second port auto direction, reset 0.
// - Mode one bit 4 is first port auto direction, reset 0.
// - Mode one bits 1 and 0 are output enables, reset 1.
// - A disabled port stops decoding its address range.
// - Mode two bit 0 fast mode; 0 scales divisor by 16.
// - Reserved bits ignore writes and read zero.
// - Mode two returns to defaults on platform reset.
// - Transceiver mode bits select RS-232 or RS-422/485 per port.
// - Second port control returns to defaults on platform reset.
`timescale 1ns/1ps
module scg_top
  import scg_pkg::*;
#(
  parameter int DIV_W = 16,
  parameter logic [15:0] PORT_A_BASE = 16'h03f8
)
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [1:0] I_REG_SEL,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  input wire logic [15:0] I_IO_ADDR,
  output logic O_PORT_A_HIT,
  output logic O_PORT_B_HIT,
  input wire logic I_PORT_B_IRQ,
  output logic [15:0] O_IRQ_SLOTS,
  input wire logic [DIV_W-1:0] I_PORT_A_DIVISOR,
  input wire logic [DIV_W-1:0] I_PORT_B_DIVISOR,
  output logic [DIV_W+3:0] O_PORT_A_DIVISOR,
  output logic [DIV_W+3:0] O_PORT_B_DIVISOR,
  input wire logic I_PORT_A_TX_PENDING,
  input wire logic I_PORT_B_TX_PENDING,
  input wire logic I_PORT_A_RTS,
  input wire logic I_PORT_B_RTS,
  input wire logic I_PORT_A_TXD,
  input wire logic I_PORT_B_TXD,
  output logic O_PORT_A_TXD,
  output logic O_PORT_B_TXD,
  output logic O_PORT_A_RTS,
  output logic O_PORT_B_RTS,
  output logic O_PORT_A_DRIVER_EN,
  output logic O_PORT_B_DRIVER_EN,
  output logic O_PORT_A_LINE_STANDARD,
  output logic O_PORT_B_LINE_STANDARD
);
  logic [7:0] second_port_control;
  logic [7:0] serial_mode_one;
  logic [7:0] serial_mode_two;
  logic [7:0] transceiver_mode_register;
  logic [7:0] rdata;
  logic [7:0] next_second_port_control;
  logic [7:0] next_serial_mode_one;
  logic [7:0] next_serial_mode_two;
  logic [7:0] next_transceiver_mode_register;
  logic [7:0] next_rdata;
  logic [15:0] port_b_base;
  logic fast_mode;

  // Base address of the second port from its select code
  function automatic logic [15:0] base_of(input logic [3:0] code);
    unique case (code)
      4'h0: base_of = 16'h03f8;
      4'h1: base_of = 16'h02f8;
      4'h2: base_of = 16'h03e8;
      4'h3: base_of = 16'h02e8;
      4'h4: base_of = 16'h0200;
      4'h5: base_of = 16'h0220;
      4'h6: base_of = 16'h0228;
      4'h7: base_of = 16'h0338;
      4'h8: base_of = 16'h0238;
      4'h9: base_of = 16'h0338;
      default: base_of = 16'h02f8; // Reserved codes, software must avoid them
    endcase
  endfunction

  // Serial IRQ slot number from the line select code
  function automatic logic [3:0] slot_of(input logic [2:0] code);
    unique case (code)
      3'h0: slot_of = 4'h3;
      3'h1: slot_of = 4'h4;
      3'h2: slot_of = 4'h5;
      3'h3: slot_of = 4'ha;
      3'h4: slot_of = 4'h6;
      3'h5: slot_of = 4'h7;
      3'h6: slot_of = 4'h9;
      3'h7: slot_of = 4'hb;
    endcase
  endfunction

  // Address window hit test
  function automatic logic in_window(input logic [15:0] addr, input logic [15:0] base);
    in_window = (addr >= base) && (addr < base + PORT_SPAN);
  endfunction

  // Effective divisor: legacy mode multiplies by 16, fast mode passes it through
  function automatic logic [DIV_W+3:0] scale_div(input logic [DIV_W-1:0] div, input logic fast);
    logic [DIV_W+3:0] wide;
    wide = {4'h0, div};
    if (fast) begin
      scale_div = wide;
    end else begin
      scale_div = wide << LEGACY_SHIFT;
    end
  endfunction

  // Register write next values; reserved bits are masked here so they always read zero
  always_comb begin
    next_second_port_control = second_port_control;
    next_serial_mode_one = serial_mode_one;
    next_serial_mode_two = serial_mode_two;
    next_transceiver_mode_register = transceiver_mode_register;
    if (I_REG_WR) begin
      unique case (I_REG_SEL)
        REG_SECOND_PORT_CONTROL: next_second_port_control = I_REG_WDATA;
        REG_SERIAL_MODE_ONE: next_serial_mode_one = I_REG_WDATA & MODE_ONE_MASK;
        REG_SERIAL_MODE_TWO: next_serial_mode_two = I_REG_WDATA & MODE_TWO_MASK;
        REG_TRANSCEIVER_MODE: next_transceiver_mode_register = I_REG_WDATA & XCVR_MASK;
      endcase
    end
  end

  // Register state, platform reset restores defaults whatever the clock enable says
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      second_port_control <= SECOND_PORT_CONTROL_RST;
      serial_mode_one <= MODE_ONE_RST;
      serial_mode_two <= MODE_TWO_RST;
      transceiver_mode_register <= XCVR_RST;
    end else if (I_CE) begin
      second_port_control <= next_second_port_control;
      serial_mode_one <= next_serial_mode_one;
      serial_mode_two <= next_serial_mode_two;
      transceiver_mode_register <= next_transceiver_mode_register;
    end
  end

  // Read-back select; a write and a read in one cycle return the old value
  always_comb begin
    next_rdata = rdata;
    if (I_REG_RD) begin
      unique case (I_REG_SEL)
        REG_SECOND_PORT_CONTROL: next_rdata = second_port_control;
        REG_SERIAL_MODE_ONE: next_rdata = serial_mode_one;
        REG_SERIAL_MODE_TWO: next_rdata = serial_mode_two;
        REG_TRANSCEIVER_MODE: next_rdata = transceiver_mode_register;
      endcase
    end
  end

  // Read data is held until the next read strobe
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      rdata <= 8'h00;
    end else if (I_CE) begin
      rdata <= next_rdata;
    end
  end

  assign O_REG_RDATA = rdata;

  // Address decode, released when a port output is disabled
  // A released window lets another device on the host bus claim that range
  assign port_b_base = base_of(second_port_control[3:0]);
  assign O_PORT_A_HIT = serial_mode_one[OUT_EN_A_BIT] & in_window(I_IO_ADDR, PORT_A_BASE);
  assign O_PORT_B_HIT = serial_mode_one[OUT_EN_B_BIT] & in_window(I_IO_ADDR, port_b_base);

  // Interrupt forwarding onto the selected serial IRQ slot
  // Every other slot stays low for this source
  always_comb begin
    O_IRQ_SLOTS = 16'h0000;
    if (second_port_control[IRQ_EN_BIT]) begin
      O_IRQ_SLOTS[slot_of(second_port_control[IRQ_SEL_LSB +: 3])] = I_PORT_B_IRQ;
    end
  end

  // Baud divisor scaling for both ports
  assign fast_mode = serial_mode_two[FAST_MODE_BIT];
  assign O_PORT_A_DIVISOR = scale_div(I_PORT_A_DIVISOR, fast_mode);
  assign O_PORT_B_DIVISOR = scale_div(I_PORT_B_DIVISOR, fast_mode);

  assign O_PORT_A_LINE_STANDARD = transceiver_mode_register[0];
  assign O_PORT_B_LINE_STANDARD = transceiver_mode_register[1];

  // First port driver control
  scg_port_drive u_port_a (
    .i_line_standard(transceiver_mode_register[0]),
    .i_auto_direction(serial_mode_one[AUTO_DIR_A_BIT]),
    .i_output_enable(serial_mode_one[OUT_EN_A_BIT]),
    .i_tx_pending(I_PORT_A_TX_PENDING),
    .i_rts(I_PORT_A_RTS),
    .i_txd(I_PORT_A_TXD),
    .o_txd(O_PORT_A_TXD),
    .o_rts(O_PORT_A_RTS),
    .o_driver_enable(O_PORT_A_DRIVER_EN)
  );

  // Second port driver control
  scg_port_drive u_port_b (
    .i_line_standard(transceiver_mode_register[1]),
    .i_auto_direction(serial_mode_one[AUTO_DIR_B_BIT]),
    .i_output_enable(serial_mode_one[OUT_EN_B_BIT]),
    .i_tx_pending(I_PORT_B_TX_PENDING),
    .i_rts(I_PORT_B_RTS),
    .i_txd(I_PORT_B_TXD),
    .o_txd(O_PORT_B_TXD),
    .o_rts(O_PORT_B_RTS),
    .o_driver_enable(O_PORT_B_DRIVER_EN)
  );
endmodule

// ---- include/scg_pkg.sv ----
// Constants for the serial port configuration glue.
// Assumes byte-wide register access with a register select index.
package scg_pkg;
  // Register select indices (no printed offsets; chosen locally)
  localparam logic [1:0] REG_SECOND_PORT_CONTROL = 2'h0;
  localparam logic [1:0] REG_SERIAL_MODE_ONE = 2'h1;
  localparam logic [1:0] REG_SERIAL_MODE_TWO = 2'h2;
  localparam logic [1:0] REG_TRANSCEIVER_MODE = 2'h3;
  // Field positions
  localparam int IRQ_EN_BIT = 7;
  localparam int IRQ_SEL_LSB = 4;
  localparam int AUTO_DIR_B_BIT = 5;
  localparam int AUTO_DIR_A_BIT = 4;
  localparam int OUT_EN_B_BIT = 1;
  localparam int OUT_EN_A_BIT = 0;
  localparam int FAST_MODE_BIT = 0;
  // Writable masks; all other bits are reserved and read zero
  localparam logic [7:0] MODE_ONE_MASK = 8'h33;
  localparam logic [7:0] MODE_TWO_MASK = 8'h01;
  localparam logic [7:0] XCVR_MASK = 8'h03;
  // Reset values
  localparam logic [7:0] SECOND_PORT_CONTROL_RST = 8'h01;
  localparam logic [7:0] MODE_ONE_RST = 8'h03;
  localparam logic [7:0] MODE_TWO_RST = 8'h00;
  localparam logic [7:0] XCVR_RST = 8'h00;
  // Divisor scaling in legacy mode: shift by four (times 16)
  localparam int LEGACY_SHIFT = 4;
  // I/O window size of a serial port
  localparam logic [15:0] PORT_SPAN = 16'h0008;
endpackage

// ---- verification/scg_core_model.sv ----
// Serial core model: pending flag, request-to-send, line data.
// Assumes the bench raises i_send while bytes wait to go out.
`timescale 1ns/1ps
module scg_core_model (
  input wire logic i_clk,
  input wire logic i_send,
  input wire logic i_rts,
  output logic o_pending,
  output logic o_rts,
  output logic o_txd
);
  logic txd = 1'b1;
  // Data toggles every clock while sending, so a stale level never passes
  always_ff @(posedge i_clk) begin
    txd <= i_send ? !txd : 1'b1;
  end
  assign o_pending = i_send;
  assign o_rts = i_rts;
  assign o_txd = txd;
endmodule

// ---- verification/scg_monitor.sv ----
// Port assertions for the configuration glue.
// Assumes binding into scg_top with matching port names.
`timescale 1ns/1ps
module scg_monitor
  import scg_pkg::*;
#(
  parameter int DIV_W = 16,
  parameter logic [15:0] PORT_A_BASE = 16'h03f8
)
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic I_REG_RD,
  input wire logic O_PORT_A_HIT,
  input wire logic I_PORT_B_IRQ,
  input wire logic [1:0] I_REG_SEL,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic [15:0] I_IO_ADDR,
  input wire logic [15:0] O_IRQ_SLOTS,
  input wire logic [DIV_W-1:0] I_PORT_A_DIVISOR,
  input wire logic [DIV_W+3:0] O_PORT_A_DIVISOR,
  input wire logic I_PORT_B_TX_PENDING,
  input wire logic I_PORT_B_RTS,
  input wire logic I_PORT_B_TXD,
  input wire logic O_PORT_B_TXD,
  input wire logic O_PORT_B_RTS,
  input wire logic O_PORT_B_DRIVER_EN,
  input wire logic O_PORT_B_LINE_STANDARD
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  // Read of the second mode register
  sequence s_read_two;
    I_CE && I_REG_RD && I_REG_SEL == REG_SERIAL_MODE_TWO;
  endsequence
  a_irq_quiet: assert property (!I_PORT_B_IRQ |-> O_IRQ_SLOTS == 16'h0000)
    else $error("slot active without request");
  a_slot_legal: assert property ($onehot0(O_IRQ_SLOTS) && (O_IRQ_SLOTS & 16'hf107) == 16'h0000)
    else $error("illegal slot pattern");
  a_reserved_zero: assert property (s_read_two |=> O_REG_RDATA[7:1] == 7'h00)
    else $error("reserved bits read nonzero");
  a_reset_clear: assert property ($rose(I_RST_N) |-> O_REG_RDATA == 8'h00)
    else $error("read data not cleared");
  a_div_scale: assert property (O_PORT_A_DIVISOR == {I_PORT_A_DIVISOR, 4'h0}
    || O_PORT_A_DIVISOR == {4'h0, I_PORT_A_DIVISOR}) else $error("bad divisor");
  a_hit_window: assert property (O_PORT_A_HIT |-> I_IO_ADDR[15:3] == PORT_A_BASE[15:3])
    else $error("hit outside window");
  a_disabled_idle: assert property (O_PORT_B_TXD != I_PORT_B_TXD |-> O_PORT_B_TXD && O_PORT_B_RTS)
    else $error("gated outputs not idle");
  a_rs232_drive: assert property (!O_PORT_B_LINE_STANDARD |-> O_PORT_B_DRIVER_EN || O_PORT_B_RTS)
    else $error("driver off in RS-232");
  a_idle_quiet: assert property (O_PORT_B_LINE_STANDARD && !I_PORT_B_TX_PENDING && I_PORT_B_RTS
    |-> !O_PORT_B_DRIVER_EN) else $error("driver on while idle");
endmodule
bind scg_top scg_monitor #(.DIV_W(DIV_W), .PORT_A_BASE(PORT_A_BASE)) mon_u (
  .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_REG_RD(I_REG_RD),
  .O_PORT_A_HIT(O_PORT_A_HIT), .I_PORT_B_IRQ(I_PORT_B_IRQ), .I_REG_SEL(I_REG_SEL),
  .O_REG_RDATA(O_REG_RDATA), .I_IO_ADDR(I_IO_ADDR), .O_IRQ_SLOTS(O_IRQ_SLOTS),
  .I_PORT_A_DIVISOR(I_PORT_A_DIVISOR), .O_PORT_A_DIVISOR(O_PORT_A_DIVISOR),
  .I_PORT_B_TX_PENDING(I_PORT_B_TX_PENDING), .I_PORT_B_RTS(I_PORT_B_RTS), .I_PORT_B_TXD(I_PORT_B_TXD),
  .O_PORT_B_TXD(O_PORT_B_TXD), .O_PORT_B_RTS(O_PORT_B_RTS), .O_PORT_B_DRIVER_EN(O_PORT_B_DRIVER_EN),
  .O_PORT_B_LINE_STANDARD(O_PORT_B_LINE_STANDARD)
);

// ---- verification/scg_top_tb.sv ----
// Self-checking bench for the configuration glue.
// Assumes core models on both ports and byte strobes on the reference clock.
`timescale 1ns/1ps
module scg_top_tb;
  import scg_pkg::*;
  logic I_REF_CLK = 1'b0, I_RST_N = 1'b0, I_CE = 1'b1, I_REG_WR = 1'b0, I_REG_RD = 1'b0, I_PORT_B_IRQ = 1'b0;
  logic [1:0] I_REG_SEL = 2'h0;
  logic [7:0] I_REG_WDATA = 8'h00, O_REG_RDATA;
  logic [15:0] I_IO_ADDR = 16'h0000, O_IRQ_SLOTS, I_PORT_A_DIVISOR = 16'h0123, I_PORT_B_DIVISOR = 16'h0456;
  logic [19:0] O_PORT_A_DIVISOR, O_PORT_B_DIVISOR;
  logic O_PORT_A_HIT, O_PORT_B_HIT, I_PORT_A_TX_PENDING, I_PORT_B_TX_PENDING, I_PORT_A_RTS, I_PORT_B_RTS;
  logic I_PORT_A_TXD, I_PORT_B_TXD, O_PORT_A_TXD, O_PORT_B_TXD, O_PORT_A_RTS, O_PORT_B_RTS;
  logic O_PORT_A_DRIVER_EN, O_PORT_B_DRIVER_EN, O_PORT_A_LINE_STANDARD, O_PORT_B_LINE_STANDARD;
  logic send_a = 1'b0, send_b = 1'b0, rts_b = 1'b0;
  int error_cnt = 0, samples_checked = 0;
  int irqn[8] = '{3, 4, 5, 10, 6, 7, 9, 11};
  logic [15:0] bas[10] = '{16'h03f8, 16'h02f8, 16'h03e8, 16'h02e8, 16'h0200,
                           16'h0220, 16'h0228, 16'h0338, 16'h0238, 16'h0338};
  scg_top dut_u (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_REG_WR(I_REG_WR),
    .I_REG_RD(I_REG_RD), .I_REG_SEL(I_REG_SEL), .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
    .I_IO_ADDR(I_IO_ADDR), .O_PORT_A_HIT(O_PORT_A_HIT), .O_PORT_B_HIT(O_PORT_B_HIT),
    .I_PORT_B_IRQ(I_PORT_B_IRQ), .O_IRQ_SLOTS(O_IRQ_SLOTS), .I_PORT_A_DIVISOR(I_PORT_A_DIVISOR),
    .I_PORT_B_DIVISOR(I_PORT_B_DIVISOR), .O_PORT_A_DIVISOR(O_PORT_A_DIVISOR),
    .O_PORT_B_DIVISOR(O_PORT_B_DIVISOR), .I_PORT_A_TX_PENDING(I_PORT_A_TX_PENDING),
    .I_PORT_B_TX_PENDING(I_PORT_B_TX_PENDING), .I_PORT_A_RTS(I_PORT_A_RTS), .I_PORT_B_RTS(I_PORT_B_RTS),
    .I_PORT_A_TXD(I_PORT_A_TXD), .I_PORT_B_TXD(I_PORT_B_TXD), .O_PORT_A_TXD(O_PORT_A_TXD),
    .O_PORT_B_TXD(O_PORT_B_TXD), .O_PORT_A_RTS(O_PORT_A_RTS), .O_PORT_B_RTS(O_PORT_B_RTS),
    .O_PORT_A_DRIVER_EN(O_PORT_A_DRIVER_EN), .O_PORT_B_DRIVER_EN(O_PORT_B_DRIVER_EN),
    .O_PORT_A_LINE_STANDARD(O_PORT_A_LINE_STANDARD), .O_PORT_B_LINE_STANDARD(O_PORT_B_LINE_STANDARD));
  scg_core_model core_a_u (.i_clk(I_REF_CLK), .i_send(send_a), .i_rts(1'b0), .o_pending(I_PORT_A_TX_PENDING),
    .o_rts(I_PORT_A_RTS), .o_txd(I_PORT_A_TXD));
  scg_core_model core_b_u (.i_clk(I_REF_CLK), .i_send(send_b), .i_rts(rts_b), .o_pending(I_PORT_B_TX_PENDING),
    .o_rts(I_PORT_B_RTS), .o_txd(I_PORT_B_TXD));
  // Reference clock
  initial begin
    forever #10 I_REF_CLK = !I_REF_CLK;
  end
  task automatic step();
    @(posedge I_REF_CLK);
    #1;
  endtask
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    step();
    I_REG_SEL = s;
    I_REG_WDATA = d;
    I_REG_WR = 1'b1;
    step();
    I_REG_WR = 1'b0;
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    step();
    I_REG_SEL = s;
    I_REG_RD = 1'b1;
    step();
    I_REG_RD = 1'b0;
    chk({12'h000, O_REG_RDATA}, {12'h000, e});
  endtask
  task automatic reset();
    I_RST_N = 1'b0;
    repeat (2) step();
    I_RST_N = 1'b1;
  endtask
  // Reset values and reserved bits
  task automatic t_regs();
    rd(2'h0, 8'h01);
    rd(2'h1, 8'h03);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    wr(2'h1, 8'hff);
    rd(2'h1, 8'h33);
    wr(2'h2, 8'hff);
    rd(2'h2, 8'h01);
    wr(2'h0, 8'hf9);
    reset();
    rd(2'h2, 8'h00);
    I_CE = 1'b0;
    wr(2'h2, 8'h01);
    I_CE = 1'b1;
    rd(2'h2, 8'h00);
    rd(2'h0, 8'h01);
  endtask
  // Slot select table, then forwarding off
  task automatic t_irq();
    I_PORT_B_IRQ = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(2'h0, {1'b1, i[2:0], 4'h1});
      chk({4'h0, O_IRQ_SLOTS}, 20'h1 << irqn[i]);
    end
    wr(2'h0, 8'h71);
    chk({4'h0, O_IRQ_SLOTS}, 20'h0);
    I_PORT_B_IRQ = 1'b0;
  endtask
  // Base decode upper edge for every legal code: last address hits, next one misses
  task automatic t_base();
    for (int i = 0; i < 10; i++) begin
      wr(2'h0, {4'h0, i[3:0]});
      I_IO_ADDR = bas[i] + 16'h0007;
      step();
      chk({19'h0, O_PORT_B_HIT}, 20'h1);
      I_IO_ADDR = bas[i] + 16'h0008;
      step();
      chk({19'h0, O_PORT_B_HIT}, 20'h0);
    end
  endtask
  // Output disable, divisor scaling, direction control
  task automatic t_port();
    wr(2'h0, 8'h01);
    I_IO_ADDR = 16'h03f8;
    step();
    chk({19'h0, O_PORT_A_HIT}, 20'h1);
    wr(2'h1, 8'h02);
    chk({18'h0, O_PORT_A_HIT, O_PORT_A_RTS}, 20'h1);
    I_IO_ADDR = 16'h02f8;
    send_b = 1'b1;
    wr(2'h1, 8'h01);
    chk({19'h0, O_PORT_B_HIT}, 20'h0);
    repeat (2) step();
    chk({18'h0, O_PORT_B_TXD, O_PORT_B_RTS}, 20'h3);
    chk(O_PORT_A_DIVISOR, 20'h01230);
    wr(2'h2, 8'h01);
    chk(O_PORT_B_DIVISOR, 20'h00456);
    wr(2'h3, 8'h03);
    chk({18'h0, O_PORT_B_LINE_STANDARD, O_PORT_A_LINE_STANDARD}, 20'h3);
    wr(2'h1, 8'h13);
    chk({19'h0, O_PORT_A_DRIVER_EN}, 20'h0);
    send_a = 1'b1;
    step();
    chk({19'h0, O_PORT_A_DRIVER_EN}, 20'h1);
    send_a = 1'b0;
    wr(2'h1, 8'h23);
    rts_b = 1'b1;
    step();
    chk({19'h0, O_PORT_B_DRIVER_EN}, 20'h1);
    send_b = 1'b0;
    step();
    chk({19'h0, O_PORT_B_DRIVER_EN}, 20'h0);
    wr(2'h1, 8'h03);
    chk({19'h0, O_PORT_B_DRIVER_EN}, 20'h0);
    rts_b = 1'b0;
    step();
    chk({19'h0, O_PORT_B_DRIVER_EN}, 20'h1);
    rts_b = 1'b1;
    wr(2'h3, 8'h00);
    chk({19'h0, O_PORT_B_DRIVER_EN}, 20'h1);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset();
    t_regs();
    t_irq();
    t_base();
    t_port();
    conclude();
  end
  // Watchdog against a hang
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule
